// >>> logic/mag_readout.sv
// read-only result registers of the three-axis field sensor
// assumes the measurement engine supplies samples with a one-cycle strobe
// and that the serial interface reads one byte address per cycle
`timescale 1ns/10ps
`default_nettype none
`include "mag_readout_map.svh"
module mag_readout (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // measurement engine
  input wire logic sample_valid,
  input wire mag_readout_pkg::sample_t sample,
  input wire mag_readout_pkg::axis_en_t axis_en,
  input wire logic [2:0] selftest_zyx,
  input wire logic selftest_valid,
  input wire logic ready_status,
  input wire mag_readout_pkg::irq_state_t irq_state,
  // register read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  import mag_readout_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    sample_t held;
    logic [2:0] st_zyx;
    logic ready;
    irq_state_t irq;
    logic [7:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [7:0] byte_sel;

  // ==========================================================
  // byte view of the bank
  function automatic logic [7:0] bank_byte(input state_t s,
                                           input logic [7:0] a);
    case (a)
      `X_FIELD_LOW_OFS: bank_byte = {s.held.x_value[4:0], 2'h0,
                                     s.st_zyx[0]};
      `X_FIELD_HIGH_OFS: bank_byte = s.held.x_value[12:5];
      `Y_FIELD_LOW_OFS: bank_byte = {s.held.y_value[4:0], 2'h0,
                                     s.st_zyx[1]};
      `Y_FIELD_HIGH_OFS: bank_byte = s.held.y_value[12:5];
      `Z_FIELD_LOW_OFS: bank_byte = {s.held.z_value[6:0],
                                     s.st_zyx[2]};
      `Z_FIELD_HIGH_OFS: bank_byte = s.held.z_value[14:7];
      `RES_LOW_OFS: bank_byte = {s.held.res_value[5:0], 1'h0,
                                 s.ready};
      `RES_HIGH_OFS: bank_byte = s.held.res_value[13:6];
      `INT_FLAGS_OFS: bank_byte = s.irq;
      default: bank_byte = 8'h00;
    endcase
  endfunction : bank_byte

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    // whole words captured in one edge so both bytes belong together
    if (sample_valid) begin
      if (axis_en.x_en) begin
        nxt_st.held.x_value = sample.x_value;
      end
      if (axis_en.y_en) begin
        nxt_st.held.y_value = sample.y_value;
      end
      if (axis_en.z_en) begin
        nxt_st.held.z_value = sample.z_value;
        nxt_st.held.res_value = sample.res_value;
      end
    end
    if (!axis_en.z_en) begin
      nxt_st.held.res_value = 14'h0000;
    end
    if (selftest_valid) begin
      nxt_st.st_zyx = selftest_zyx;
    end
    nxt_st.ready = ready_status;
    nxt_st.irq = irq_state;
    // read data comes from the registered bank, one cycle after address
    byte_sel = bank_byte(st_ff, rd_addr);
    nxt_st.rdata = byte_sel;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.st_zyx <= {3{`SELFTEST_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rdata;

  // ==========================================================
  // checks
  sequence s_zero_res;
    !axis_en.z_en;
  endsequence

  property p_x_low;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `X_FIELD_LOW_OFS |=> rd_data ==
      {$past(st_ff.held.x_value[4:0]), 2'h0, $past(st_ff.st_zyx[0])};
  endproperty
  a_x_low: assert property (p_x_low) else $error("x low byte");

  property p_y_high;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `Y_FIELD_HIGH_OFS |=> rd_data ==
      $past(st_ff.held.y_value[12:5]);
  endproperty
  a_y_high: assert property (p_y_high) else $error("y high byte");

  property p_z_low;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `Z_FIELD_LOW_OFS |=> rd_data[7:1] ==
      $past(st_ff.held.z_value[6:0]);
  endproperty
  a_z_low: assert property (p_z_low) else $error("z low byte");

  property p_res_low;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `RES_LOW_OFS |=> rd_data[1] == 1'b0 &&
      rd_data[0] == $past(st_ff.ready);
  endproperty
  a_res_low: assert property (p_res_low) else $error("res low");

  // status taken at one edge shows in a read addressed on the next
  sequence s_ready_read;
    ready_status ##1 (rd_addr == `RES_LOW_OFS);
  endsequence

  property p_ready;
    @(posedge clk_sys) disable iff (!rstn)
    s_ready_read |=> rd_data[`READY_BIT];
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit");

  property p_irq;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `INT_FLAGS_OFS |=> rd_data[`OVERRUN_BIT] ==
      $past(st_ff.irq.overrun, 1) && rd_data[`OVERFLOW_BIT] ==
      $past(st_ff.irq.overflow, 1);
  endproperty
  a_irq: assert property (p_irq) else $error("irq byte");

  property p_thr;
    @(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> st_ff.irq.high_zyx == $past(irq_state.high_zyx) &&
      st_ff.irq.low_zyx == $past(irq_state.low_zyx);
  endproperty
  a_thr: assert property (p_thr) else $error("thresholds");

  property p_hold_x;
    @(posedge clk_sys) disable iff (!rstn)
    !axis_en.x_en |=> $stable(st_ff.held.x_value);
  endproperty
  a_hold_x: assert property (p_hold_x) else $error("x not held");

  property p_res_zero;
    @(posedge clk_sys) disable iff (!rstn)
    s_zero_res |=> st_ff.held.res_value == 14'h0000;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("res not 0");

  property p_pair;
    @(posedge clk_sys) disable iff (!rstn)
    sample_valid && axis_en.y_en |=> st_ff.held.y_value ==
      $past(sample.y_value);
  endproperty
  a_pair: assert property (p_pair) else $error("y not paired");

  property p_x_high;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `X_FIELD_HIGH_OFS |=> rd_data ==
      $past(st_ff.held.x_value[12:5]);
  endproperty
  a_x_high: assert property (p_x_high) else $error("x high byte");

  property p_y_low;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `Y_FIELD_LOW_OFS |=> rd_data ==
      {$past(st_ff.held.y_value[4:0]), 2'h0, $past(st_ff.st_zyx[1])};
  endproperty
  a_y_low: assert property (p_y_low) else $error("y low byte");

  property p_z_high;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `Z_FIELD_HIGH_OFS |=> rd_data ==
      $past(st_ff.held.z_value[14:7]);
  endproperty
  a_z_high: assert property (p_z_high) else $error("z high byte");

  property p_res_high;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `RES_HIGH_OFS |=> rd_data ==
      $past(st_ff.held.res_value[13:6]);
  endproperty
  a_res_high: assert property (p_res_high) else $error("res high");

  property p_irq_low;
    @(posedge clk_sys) disable iff (!rstn)
    rd_addr == `INT_FLAGS_OFS |=> rd_data[5:0] ==
      {$past(st_ff.irq.high_zyx), $past(st_ff.irq.low_zyx)};
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("flags");

  property p_hold_z;
    @(posedge clk_sys) disable iff (!rstn)
    s_zero_res |=> $stable(st_ff.held.z_value);
  endproperty
  a_hold_z: assert property (p_hold_z) else $error("z not held");

  property p_st_cap;
    @(posedge clk_sys) disable iff (!rstn)
    selftest_valid |=> st_ff.st_zyx == $past(selftest_zyx);
  endproperty
  a_st_cap: assert property (p_st_cap) else $error("st capture");

  // a result and its resistance land in the same edge
  property p_pair_z;
    @(posedge clk_sys) disable iff (!rstn)
    sample_valid && axis_en.z_en |=> st_ff.held.z_value ==
      $past(sample.z_value) && st_ff.held.res_value ==
      $past(sample.res_value);
  endproperty
  a_pair_z: assert property (p_pair_z) else $error("z not paired");

  property p_st_reset;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> st_ff.st_zyx == 3'h7;
  endproperty
  a_st_reset: assert property (p_st_reset) else $error("st reset");
endmodule : mag_readout
`default_nettype wire

// >>> logic/mag_readout_map.svh
// register offsets, field positions and reset values of the result bank
// assumes byte-wide register reads from the serial interface logic
//
// Summary of operation
// - x field bits 4..0 in low byte 7..3, 12..5 in high byte; 2..1 zero
// - y field bits 4..0 in low byte 7..3, 12..5 in high byte; 2..1 zero
// - z field bits 6..0 in low byte 7..1, 14..7 in high byte
// - resistance bits 5..0 in low byte 7..2, 13..6 in high; bit 1 zero
// - low byte bit 0 of x, y, z holds self-test flag, one after reset
// - resistance low byte bit 0 shows result ready status
// - interrupt byte: bit 7 data overrun, bit 6 overflow
// - interrupt byte: bits 5, 4, 3 are z, y, x high-threshold flags
// - interrupt byte: bits 2, 1, 0 are z, y, x low-threshold flags
// - a disabled axis keeps its last measured value
// - z disabled stops resistance and forces its value to zero
`ifndef MAG_READOUT_MAP_SVH
`define MAG_READOUT_MAP_SVH
`define X_FIELD_LOW_OFS 8'h42
`define X_FIELD_HIGH_OFS 8'h43
`define Y_FIELD_LOW_OFS 8'h44
`define Y_FIELD_HIGH_OFS 8'h45
`define Z_FIELD_LOW_OFS 8'h46
`define Z_FIELD_HIGH_OFS 8'h47
`define RES_LOW_OFS 8'h48
`define RES_HIGH_OFS 8'h49
`define INT_FLAGS_OFS 8'h4a
`define SELFTEST_RESET 1'h1
`define READY_BIT 0
`define OVERRUN_BIT 7
`define OVERFLOW_BIT 6
`endif

// >>> logic/mag_readout_pkg.sv
// types shared by the result bank and its users
// assumes the map header is included alongside
`default_nettype none
package mag_readout_pkg;
  typedef struct packed {
    logic [12:0] x_value;
    logic [12:0] y_value;
    logic [14:0] z_value;
    logic [13:0] res_value;
  } sample_t;
  typedef struct packed {
    logic overrun;
    logic overflow;
    logic [2:0] high_zyx;
    logic [2:0] low_zyx;
  } irq_state_t;
  typedef struct packed {
    logic x_en;
    logic y_en;
    logic z_en;
  } axis_en_t;
endpackage : mag_readout_pkg
`default_nettype wire

// >>> tb/host_model.sv
// host side model: reads one result byte per call over the read port
// assumes rd_data answers after the edge that takes rd_addr
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_sys,
  // register read port
  output var logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial rd_addr = 8'h00;
  // =========================================================
  // read cycle
  // address moves only at the falling edge, so the taking edge sees it stable
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    rd_addr = a;
    @(posedge clk_sys);
    #1 d = rd_data;
  endtask : read
endmodule : host_model
`default_nettype wire

// >>> tb/tb_mag_readout.sv
// bench for the result bank: drives samples and flags, reads bytes back
// assumes host_model gives one byte per read, answer one edge after address
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_mag_readout;
  import mag_readout_pkg::*;
  logic clk_sys = 0, rstn = 0, sample_valid = 0, selftest_valid = 0;
  logic ready_status = 0;
  logic [2:0] selftest_zyx = 3'h7;
  sample_t sample = '0;
  axis_en_t axis_en = 3'h7;
  irq_state_t irq_state = '0;
  logic [7:0] rd_addr, rd_data, b;
  int n_errors = 0, num_checks = 0, cyc = 0;
  sample_t s1, s2, e;
  always #4 clk_sys = ~clk_sys;
  mag_readout mag_readout_i (.clk_sys(clk_sys), .rstn(rstn),
    .sample_valid(sample_valid), .sample(sample), .axis_en(axis_en),
    .selftest_zyx(selftest_zyx), .selftest_valid(selftest_valid),
    .ready_status(ready_status), .irq_state(irq_state),
    .rd_addr(rd_addr), .rd_data(rd_data));
  host_model host_model_i (.clk_sys(clk_sys), .rd_addr(rd_addr),
    .rd_data(rd_data));
  // =========================================================
  // tasks
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] ex);
    host_model_i.read(a, b);
    `CHK($sformatf("reg %h", a), ex, b)
  endtask : chk_rd
  task automatic put(input sample_t s);
    @(negedge clk_sys);
    sample = s;
    sample_valid = 1;
    @(negedge clk_sys);
    sample_valid = 0;
  endtask : put
  task automatic chk_all(input sample_t s, input logic [2:0] st,
                         input logic rdy);
    chk_rd(8'h42, {s.x_value[4:0], 2'b00, st[0]});
    chk_rd(8'h43, s.x_value[12:5]);
    chk_rd(8'h44, {s.y_value[4:0], 2'b00, st[1]});
    chk_rd(8'h45, s.y_value[12:5]);
    chk_rd(8'h46, {s.z_value[6:0], st[2]});
    chk_rd(8'h47, s.z_value[14:7]);
    chk_rd(8'h48, {s.res_value[5:0], 1'b0, rdy});
    chk_rd(8'h49, s.res_value[13:6]);
  endtask : chk_all
  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // =========================================================
  // timeout: whole sequence needs well under 300 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // =========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1;
    chk_all('0, 3'h7, 1'b0);
    s1 = {13'h1abc, 13'h0a55, 15'h5a5b, 14'h2b6d};
    @(negedge clk_sys);
    ready_status = 1;
    put(s1);
    chk_all(s1, 3'h7, 1'b1);
    // walking one shows every flag lands in its own bit
    for (int i = 0; i < 8; i++) begin
      // flags reach the bank one edge after they are set
      @(negedge clk_sys);
      irq_state = 8'(1 << i);
      chk_rd(8'h4a, 8'(1 << i));
    end
    @(negedge clk_sys);
    selftest_zyx = 3'b010;
    selftest_valid = 1;
    @(negedge clk_sys);
    selftest_valid = 0;
    chk_all(s1, 3'b010, 1'b1);
    // x and z off: y moves, x and z hold, resistance forced to zero
    @(negedge clk_sys);
    axis_en = 3'b010;
    s2 = {13'h0123, 13'h1f0f, 15'h7001, 14'h3fff};
    ready_status = 0;
    put(s2);
    e = {s1.x_value, s2.y_value, s1.z_value, 14'h0000};
    chk_all(e, 3'b010, 1'b0);
    chk_rd(8'h41, 8'h00);
    report_and_stop();
  end
endmodule : tb_mag_readout
`default_nettype wire
